// ==== rtl/capwd_pkg.sv ====
/*
  Constants, register map and types for the counter array output functions and watchdog.
  Assumes a single system clock domain; software reaches the registers over APB.
*/
`default_nettype none

package capwd_pkg;

  // Register byte offsets, one aligned 32-bit word per 8-bit register
  localparam logic [7:0] CAPWD_OFF_CTRL = 8'h00;
  localparam logic [7:0] CAPWD_OFF_MODE = 8'h04;
  localparam logic [7:0] CAPWD_OFF_CNT_L = 8'h08;
  localparam logic [7:0] CAPWD_OFF_CNT_H = 8'h0C;
  localparam logic [7:0] CAPWD_OFF_CPM_BASE = 8'h10;
  localparam logic [7:0] CAPWD_OFF_CPL_BASE = 8'h20;
  localparam logic [7:0] CAPWD_OFF_CPH_BASE = 8'h30;

  // Control register fields (low bits hold the module event flags)
  localparam int unsigned CAPWD_CTRL_CF_BIT = 7;
  localparam int unsigned CAPWD_CTRL_CR_BIT = 6;

  // Counter mode register fields
  localparam int unsigned CAPWD_MODE_IDLE_BIT = 7;
  localparam int unsigned CAPWD_MODE_WDE_BIT = 6;
  localparam int unsigned CAPWD_MODE_LCK_BIT = 5;
  localparam int unsigned CAPWD_MODE_CPS_LSB = 1;
  localparam int unsigned CAPWD_MODE_ECF_BIT = 0;

  // Reset values
  localparam logic [7:0] CAPWD_CTRL_RST = 8'h00;
  localparam logic [7:0] CAPWD_MODE_RST = 8'h40;
  localparam logic [7:0] CAPWD_CPM_RST = 8'h00;
  localparam logic [7:0] CAPWD_BYTE_RST = 8'h00;

  // Count source codes
  localparam logic [2:0] CAPWD_CPS_DIV12 = 3'h0;
  localparam logic [2:0] CAPWD_CPS_DIV4 = 3'h1;
  localparam logic [2:0] CAPWD_CPS_TMR0 = 3'h2;
  localparam logic [2:0] CAPWD_CPS_ECI = 3'h3;
  localparam logic [2:0] CAPWD_CPS_SYS = 3'h4;
  localparam logic [2:0] CAPWD_CPS_EXT8 = 3'h5;

  // Prescaler divisors as last count values (divide by 12, 4 and 8)
  localparam logic [3:0] CAPWD_DIV12_LAST = 4'hB;
  localparam logic [1:0] CAPWD_DIV4_LAST = 2'h3;
  localparam logic [2:0] CAPWD_DIV8_LAST = 3'h7;

  // Module mode register layout, bit 7 first
  typedef struct packed {
    logic wide_pwm_select;
    logic compare_enable;
    logic cap_pos;
    logic cap_neg;
    logic match_enable;
    logic toggle_enable;
    logic pwm_enable;
    logic match_irq_enable;
  } capwd_cpm_t;

  typedef enum logic [1:0] {
    CAPWD_OP_OTHER = 2'b00,
    CAPWD_OP_FREQ = 2'b01,
    CAPWD_OP_PWM8 = 2'b10,
    CAPWD_OP_PWM16 = 2'b11
  } capwd_op_t;

  function automatic logic [7:0] capwd_mod_off(input logic [7:0] base, input int unsigned idx);
    return base + 8'(idx * 4);
  endfunction

endpackage

`default_nettype wire

// ==== rtl/capwd_top.sv ====
/*
  Counter array: 16-bit counter, compare modules with frequency output, 8-bit and 16-bit
  PWM, and the watchdog built on module two, with an APB register slave.
  Assumes cpu_idle and tmr0_ovf come from logic on mclk; eci_pin and ext_osc_pin are
  asynchronous pins. The watchdog reset pulse goes to the system reset logic.
*/
// Design decisions made here: the APB register port and the address map.
// Overview of operation
// - Frequency mode toggles pin, advances low compare.
// - Compare, toggle, pwm enables select frequency mode.
// - High byte zero means 256 clock step.
// - 8-bit PWM: match sets, low overflow clears.
// - Low byte wrap reloads compare low from high.
// - Compare, pwm set, toggle, wide clear: 8-bit PWM.
// - Low write clears compare enable, high sets.
// - 8-bit duty is (256 - high) / 256.
// - Compare enable clear holds PWM output low.
// - 16-bit PWM: match sets, overflow clears.
// - Compare, pwm, wide set, toggle clear: 16-bit PWM.
// - 16-bit duty is (65536 - word) / 65536.
// - Watchdog uses module two high/low bytes.
// - Watchdog forces counter, freezes listed registers.
// - Run bit cannot stop counter; reads software value.
// - Compare byte write loads counter high plus offset.
// - Reset on low overflow with compare match.
// - Writing one to module two flag forces reset.
// - Enable or lock enables; lock holds till reset.
// - Reset: watchdog on, divide 12, bytes zero.
// - Mode register writes, except enable and lock, ignored while watchdog enabled.
`default_nettype none
`timescale 1ns/100ps

module capwd_top
  import capwd_pkg::*;
#(
  parameter int unsigned NMOD = 3,
  parameter int unsigned WD_MOD = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_idle,
  input wire logic tmr0_ovf,
  input wire logic eci_pin,
  input wire logic ext_osc_pin,
  output logic [NMOD-1:0] module_output_pin,
  output logic watchdog_reset_pulse
);

  function automatic capwd_op_t op_decode(input capwd_cpm_t m);
    capwd_op_t op;
    op = CAPWD_OP_OTHER;
    if (m.compare_enable && m.pwm_enable) begin
      if (m.toggle_enable) begin
        op = CAPWD_OP_FREQ;
      end else if (m.wide_pwm_select) begin
        op = CAPWD_OP_PWM16;
      end else begin
        op = CAPWD_OP_PWM8;
      end
    end
    return op;
  endfunction

  // Register state
  logic [7:0] cnt_l_r, cnt_h_r, snap_h_r;
  logic cf_r, cr_r;
  logic [NMOD-1:0] ccf_r;
  logic idle_r, wde_r, lck_r;
  logic [2:0] cps_r;
  logic ecf_r;
  capwd_cpm_t cpm_r [NMOD];
  logic [7:0] cpl_r [NMOD];
  logic [7:0] cph_r [NMOD];
  logic [NMOD-1:0] pin_r;
  logic wd_rst_r;
  logic [31:0] prdata_r;
  logic err_r;

  // Count source state
  logic [3:0] pre12_r;
  logic [1:0] pre4_r;
  logic eci_s1_r, eci_s2_r, eci_s3_r;
  logic ext_s1_r, ext_s2_r, ext_s3_r;
  logic [2:0] ext_div_r;

  // APB decode
  logic setup, wr_acc, rd_acc;
  logic wr_ctrl, wr_mode, wr_cl, wr_ch;
  logic [NMOD-1:0] wr_cpm, wr_cpl, wr_cph;
  logic [7:0] wbyte;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign wbyte = pwdata[7:0];
  assign wr_ctrl = wr_acc && (paddr == CAPWD_OFF_CTRL);
  assign wr_mode = wr_acc && (paddr == CAPWD_OFF_MODE);
  assign wr_cl = wr_acc && (paddr == CAPWD_OFF_CNT_L);
  assign wr_ch = wr_acc && (paddr == CAPWD_OFF_CNT_H);

  always_comb begin
    for (int i = 0; i < NMOD; i++) begin
      wr_cpm[i] = wr_acc && (paddr == capwd_mod_off(CAPWD_OFF_CPM_BASE, i));
      wr_cpl[i] = wr_acc && (paddr == capwd_mod_off(CAPWD_OFF_CPL_BASE, i));
      wr_cph[i] = wr_acc && (paddr == capwd_mod_off(CAPWD_OFF_CPH_BASE, i));
    end
  end

  // Watchdog enable and counter tick
  logic wd_en, run, src_tick, tick;
  logic [15:0] cnt, cnt_nxt;
  logic lo_wrap, ov16;

  assign wd_en = wde_r || lck_r;
  assign run = (cr_r || wd_en) && !(idle_r && cpu_idle);
  assign cnt = {cnt_h_r, cnt_l_r};
  assign cnt_nxt = cnt + 16'h0001;
  assign tick = run && src_tick;
  assign lo_wrap = tick && (cnt_l_r == 8'hFF);
  assign ov16 = tick && (cnt == 16'hFFFF);

  always_comb begin
    unique case (cps_r)
      CAPWD_CPS_DIV12: src_tick = (pre12_r == CAPWD_DIV12_LAST);
      CAPWD_CPS_DIV4: src_tick = (pre4_r == CAPWD_DIV4_LAST);
      CAPWD_CPS_TMR0: src_tick = tmr0_ovf;
      CAPWD_CPS_ECI: src_tick = eci_s3_r && !eci_s2_r;
      CAPWD_CPS_SYS: src_tick = 1'b1;
      CAPWD_CPS_EXT8: src_tick = ext_s2_r && !ext_s3_r && (ext_div_r == CAPWD_DIV8_LAST);
      default: src_tick = 1'b0;
    endcase
  end

  // Prescalers run freely so a source change never stalls
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre12_r <= 4'h0;
      pre4_r <= 2'h0;
    end else begin
      pre12_r <= (pre12_r == CAPWD_DIV12_LAST) ? 4'h0 : pre12_r + 4'h1;
      pre4_r <= pre4_r + 2'h1;
    end
  end

  // Pin synchronisers and edge history
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {eci_s3_r, eci_s2_r, eci_s1_r} <= 3'h0;
      {ext_s3_r, ext_s2_r, ext_s1_r} <= 3'h0;
    end else begin
      {eci_s3_r, eci_s2_r, eci_s1_r} <= {eci_s2_r, eci_s1_r, eci_pin};
      {ext_s3_r, ext_s2_r, ext_s1_r} <= {ext_s2_r, ext_s1_r, ext_osc_pin};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_div_r <= 3'h0;
    end else if (ext_s2_r && !ext_s3_r) begin
      ext_div_r <= ext_div_r + 3'h1;
    end
  end

  // Counter; software writes are ignored under the watchdog
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_l_r <= CAPWD_BYTE_RST;
      cnt_h_r <= CAPWD_BYTE_RST;
    end else begin
      if (wr_cl && !wd_en) begin
        cnt_l_r <= wbyte;
      end else if (tick) begin
        cnt_l_r <= cnt_nxt[7:0];
      end
      if (wr_ch && !wd_en) begin
        cnt_h_r <= wbyte;
      end else if (tick) begin
        cnt_h_r <= cnt_nxt[15:8];
      end
    end
  end

  // Reading the low byte latches the high byte in the access phase, one clock after the low byte is sampled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      snap_h_r <= CAPWD_BYTE_RST;
    end else if (rd_acc && paddr == CAPWD_OFF_CNT_L) begin
      snap_h_r <= cnt_h_r;
    end
  end

  // Counter mode register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idle_r <= CAPWD_MODE_RST[CAPWD_MODE_IDLE_BIT];
      wde_r <= CAPWD_MODE_RST[CAPWD_MODE_WDE_BIT];
      lck_r <= CAPWD_MODE_RST[CAPWD_MODE_LCK_BIT];
      cps_r <= CAPWD_MODE_RST[CAPWD_MODE_CPS_LSB +: 3];
      ecf_r <= CAPWD_MODE_RST[CAPWD_MODE_ECF_BIT];
    end else if (wr_mode) begin
      if (wd_en) begin
        // Only the enable and lock take effect while the watchdog runs
        wde_r <= lck_r ? wde_r : wbyte[CAPWD_MODE_WDE_BIT];
        lck_r <= lck_r || wbyte[CAPWD_MODE_LCK_BIT];
      end else begin
        idle_r <= wbyte[CAPWD_MODE_IDLE_BIT];
        wde_r <= wbyte[CAPWD_MODE_WDE_BIT];
        lck_r <= wbyte[CAPWD_MODE_LCK_BIT];
        cps_r <= wbyte[CAPWD_MODE_CPS_LSB +: 3];
        ecf_r <= wbyte[CAPWD_MODE_ECF_BIT];
      end
    end
  end

  // Per-module effective mode and match detection
  capwd_op_t op [NMOD];
  logic [NMOD-1:0] match_evt, wd_mod;

  always_comb begin
    for (int i = 0; i < NMOD; i++) begin
      wd_mod[i] = wd_en && (i == WD_MOD);
      // Watchdog module runs as a plain timer with no pin activity
      op[i] = wd_mod[i] ? CAPWD_OP_OTHER : op_decode(cpm_r[i]);
      match_evt[i] = tick && cpm_r[i].match_enable && cpm_r[i].compare_enable &&
        ((op[i] == CAPWD_OP_PWM8) ? (cnt_l_r == cpl_r[i]) : (cnt == {cph_r[i], cpl_r[i]}));
    end
  end

  // Control register: set by hardware wins over a software clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cf_r <= CAPWD_CTRL_RST[CAPWD_CTRL_CF_BIT];
      cr_r <= CAPWD_CTRL_RST[CAPWD_CTRL_CR_BIT];
      ccf_r <= CAPWD_CTRL_RST[NMOD-1:0];
    end else begin
      if (wr_ctrl) begin
        cr_r <= wbyte[CAPWD_CTRL_CR_BIT];
        cf_r <= wbyte[CAPWD_CTRL_CF_BIT] || ov16;
        ccf_r <= wbyte[NMOD-1:0] | match_evt;
      end else begin
        cf_r <= cf_r || ov16;
        ccf_r <= ccf_r | match_evt;
      end
    end
  end

  // Compare bytes and module mode registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NMOD; i++) begin
        cpm_r[i] <= CAPWD_CPM_RST;
        cpl_r[i] <= CAPWD_BYTE_RST;
        cph_r[i] <= CAPWD_BYTE_RST;
      end
    end else begin
      for (int i = 0; i < NMOD; i++) begin
        if (wr_cpm[i] && !wd_mod[i]) begin
          cpm_r[i] <= capwd_cpm_t'(wbyte);
        end
        if (wr_cph[i]) begin
          cpm_r[i].compare_enable <= 1'b1;
        end else if (wr_cpl[i]) begin
          cpm_r[i].compare_enable <= 1'b0;
        end
        if (wr_cpl[i]) begin
          cpl_r[i] <= wbyte;
        end else if (op[i] == CAPWD_OP_FREQ && tick && cnt_l_r == cpl_r[i]) begin
          // Adding zero lands on the same point one full wrap later
          cpl_r[i] <= cpl_r[i] + cph_r[i];
        end else if (op[i] == CAPWD_OP_PWM8 && lo_wrap) begin
          cpl_r[i] <= cph_r[i];
        end
        if (wr_cph[i]) begin
          if (wd_mod[i]) begin
            cph_r[i] <= cnt_h_r + cpl_r[i];
          end else begin
            cph_r[i] <= wbyte;
          end
        end
      end
    end
  end

  // Module output pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_r <= '0;
    end else begin
      for (int i = 0; i < NMOD; i++) begin
        if (!wd_mod[i] && cpm_r[i].pwm_enable && !cpm_r[i].compare_enable) begin
          pin_r[i] <= 1'b0;
        end else if (tick) begin
          unique case (op[i])
            CAPWD_OP_FREQ: pin_r[i] <= pin_r[i] ^ (cnt_l_r == cpl_r[i]);
            CAPWD_OP_PWM8: begin
              // Wrap clears unless the reloaded point is zero
              if (cnt_nxt[7:0] == 8'h00) begin
                pin_r[i] <= (cph_r[i] == 8'h00);
              end else if (cnt_nxt[7:0] == cpl_r[i]) begin
                pin_r[i] <= 1'b1;
              end
            end
            CAPWD_OP_PWM16: begin
              if (cnt_nxt == 16'h0000) begin
                pin_r[i] <= ({cph_r[i], cpl_r[i]} == 16'h0000);
              end else if (cnt_nxt == {cph_r[i], cpl_r[i]}) begin
                pin_r[i] <= 1'b1;
              end
            end
            CAPWD_OP_OTHER: pin_r[i] <= pin_r[i];
          endcase
        end
      end
    end
  end

  assign module_output_pin = pin_r;

  // Watchdog reset request
  logic wd_fire;

  assign wd_fire = wd_en &&
    ((lo_wrap && cph_r[WD_MOD] == cnt_h_r) ||
     (wr_ctrl && wbyte[WD_MOD]));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wd_rst_r <= 1'b0;
    end else begin
      wd_rst_r <= wd_fire;
    end
  end

  assign watchdog_reset_pulse = wd_rst_r;

  // APB read data and error, registered in the setup phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b1;
      if (paddr == CAPWD_OFF_CTRL) begin
        prdata_r[7:0] <= {cf_r, cr_r, {(6 - NMOD){1'b0}}, ccf_r};
        err_r <= 1'b0;
      end
      if (paddr == CAPWD_OFF_MODE) begin
        prdata_r[7:0] <= {idle_r, wde_r, lck_r, 1'b0, cps_r, ecf_r};
        err_r <= 1'b0;
      end
      if (paddr == CAPWD_OFF_CNT_L) begin
        prdata_r[7:0] <= cnt_l_r;
        err_r <= 1'b0;
      end
      if (paddr == CAPWD_OFF_CNT_H) begin
        prdata_r[7:0] <= snap_h_r;
        err_r <= 1'b0;
      end
      for (int i = 0; i < NMOD; i++) begin
        if (paddr == capwd_mod_off(CAPWD_OFF_CPM_BASE, i)) begin
          prdata_r[7:0] <= cpm_r[i];
          err_r <= 1'b0;
        end
        if (paddr == capwd_mod_off(CAPWD_OFF_CPL_BASE, i)) begin
          prdata_r[7:0] <= cpl_r[i];
          err_r <= 1'b0;
        end
        if (paddr == capwd_mod_off(CAPWD_OFF_CPH_BASE, i)) begin
          prdata_r[7:0] <= cph_r[i];
          err_r <= 1'b0;
        end
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_r;

endmodule // capwd_top

`default_nettype wire

// ==== tb/capwd_checker.sv ====
/*
  Port checker for capwd_top: APB answers, mode register reads, watchdog pulse.
  Bound to every capwd_top instance; one clock domain, reset active high.
*/
`default_nettype none
`timescale 1ns/100ps

module capwd_checker
  import capwd_pkg::*;
#(
  parameter int unsigned NMOD = 3,
  parameter int unsigned WD_MOD = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_idle,
  input wire logic tmr0_ovf,
  input wire logic eci_pin,
  input wire logic ext_osc_pin,
  input wire logic [NMOD-1:0] module_output_pin,
  input wire logic watchdog_reset_pulse
);
  logic [7:0] mode_r;
  logic wd_en;
  logic acc;
  logic mapped;

  assign acc = psel && penable;
  assign wd_en = mode_r[6] || mode_r[5];
  assign mapped = (paddr[1:0] == 2'h0) && ((paddr <= 8'h0C) ||
    ((paddr[7:4] inside {4'h1, 4'h2, 4'h3}) && (paddr[3:2] != 2'h3)));

  // Expected counter mode register contents
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_r <= 8'h40;
    end else if (acc && pwrite && paddr == CAPWD_OFF_MODE) begin
      if (!wd_en) begin
        mode_r <= pwdata[7:0] & 8'hEF;
      end else begin
        mode_r[6] <= mode_r[5] ? mode_r[6] : pwdata[6];
        mode_r[5] <= mode_r[5] | pwdata[5];
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence mode_rd_s;
    acc && !pwrite && paddr == CAPWD_OFF_MODE;
  endsequence

  sequence force_wr_s;
    acc && pwrite && paddr == CAPWD_OFF_CTRL && pwdata[2] && wd_en;
  endsequence

  apb_ready_a: assert property (pready)
    else $error("pready low");
  slverr_map_a: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  slverr_idle_a: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access phase");
  unmapped_rd_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  mode_read_a: assert property (mode_rd_s |-> prdata == {24'h0, mode_r})
    else $error("mode register read wrong");
  pulse_single_a: assert property (watchdog_reset_pulse |=> !watchdog_reset_pulse)
    else $error("watchdog pulse longer than one cycle");
  force_pulse_a: assert property (force_wr_s |=> watchdog_reset_pulse)
    else $error("forced watchdog reset missing");
  pulse_gate_a: assert property (!wd_en && !$past(wd_en) |-> !watchdog_reset_pulse)
    else $error("watchdog pulse while disabled");
  reset_out_a: assert property ($fell(rst) |-> module_output_pin == '0 && !watchdog_reset_pulse)
    else $error("outputs not idle after reset");

endmodule // capwd_checker

bind capwd_top capwd_checker #(.NMOD(NMOD), .WD_MOD(WD_MOD)) i_chk (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cpu_idle(cpu_idle), .tmr0_ovf(tmr0_ovf), .eci_pin(eci_pin),
  .ext_osc_pin(ext_osc_pin), .module_output_pin(module_output_pin),
  .watchdog_reset_pulse(watchdog_reset_pulse)
);

`default_nettype wire

// ==== tb/test_capwd_top.sv ====
/*
  Self-checking bench for capwd_top: watchdog, 8/16-bit PWM, frequency output.
  Drives APB itself; counter source pins tied idle, divide-by-12 source in the default test, system clock source after.
*/
`default_nettype none
`timescale 1ns/100ps

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t got %0h expected %0h", $time, (g), (e)); end end

module test_capwd_top
  import capwd_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] pin;
  logic wd_pulse;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int t0 = 0;
  int c = 0;

  capwd_top i_dut (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_idle(1'b0), .tmr0_ovf(1'b0), .eci_pin(1'b0),
    .ext_osc_pin(1'b0), .module_output_pin(pin), .watchdog_reset_pulse(wd_pulse)
  );

  initial begin
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t0 = cyc;
  endtask

  task automatic wait_pulse(input int lim);
    int n;
    n = 0;
    while (wd_pulse !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  task automatic count_high(input int i, input int n);
    c = 0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      if (pin[i] === 1'b1) c++;
    end
  endtask

  task automatic wait_toggle(input int i);
    logic v;
    v = pin[i];
    c = 0;
    do begin
      @(posedge mclk);
      #1;
      c++;
    end while (pin[i] === v && c < 700);
  endtask

  task automatic t_defaults;
    apb(1'b0, CAPWD_OFF_MODE, 8'h00);
    `CHK(rd[7:0], 8'h40)
    apb(1'b0, CAPWD_OFF_CPL_BASE + 8'h08, 8'h00);
    `CHK(rd[7:0], 8'h00)
    apb(1'b0, 8'h3C, 8'h00);
    `CHK({err, rd}, {1'b1, 32'h0})
    wait_pulse(3300);
    `CHK((cyc - t0) inside {[3060:3085]}, 1'b1)
  endtask

  task automatic t_update;
    apb(1'b1, CAPWD_OFF_MODE, 8'h00);
    apb(1'b1, CAPWD_OFF_MODE, 8'h08);
    apb(1'b1, CAPWD_OFF_CPL_BASE + 8'h08, 8'h02);
    apb(1'b1, CAPWD_OFF_MODE, 8'h48);
    apb(1'b1, CAPWD_OFF_MODE, 8'h4E);
    apb(1'b1, CAPWD_OFF_CPH_BASE + 8'h08, 8'h00);
    t0 = cyc;
    apb(1'b0, CAPWD_OFF_MODE, 8'h00);
    `CHK(rd[7:0], 8'h48)
    apb(1'b1, CAPWD_OFF_CNT_H, 8'h80);
    apb(1'b1, CAPWD_OFF_CTRL, 8'h00);
    apb(1'b0, CAPWD_OFF_CNT_L, 8'h00);
    apb(1'b0, CAPWD_OFF_CNT_H, 8'h00);
    `CHK(rd[7:4], 4'h0)
    apb(1'b0, CAPWD_OFF_CTRL, 8'h00);
    `CHK(rd[6], 1'b0)
    wait_pulse(900);
    `CHK((cyc - t0) inside {[511:772]}, 1'b1)
    apb(1'b1, CAPWD_OFF_MODE, 8'h28);
    apb(1'b1, CAPWD_OFF_MODE, 8'h00);
    apb(1'b0, CAPWD_OFF_MODE, 8'h00);
    `CHK(rd[7:0], 8'h28)
    apb(1'b1, CAPWD_OFF_CTRL, 8'h04);
    #1 `CHK(wd_pulse, 1'b1)
  endtask

  task automatic t_pwm8;
    int v[3] = '{0, 128, 255};
    @(posedge mclk);
    do_reset();
    apb(1'b1, CAPWD_OFF_MODE, 8'h00);
    apb(1'b1, CAPWD_OFF_MODE, 8'h08);
    apb(1'b1, CAPWD_OFF_CTRL, 8'h44);
    #1 `CHK(wd_pulse, 1'b0)
    apb(1'b1, CAPWD_OFF_CPM_BASE, 8'h42);
    apb(1'b1, CAPWD_OFF_CPL_BASE, 8'h00);
    foreach (v[k]) begin
      apb(1'b1, CAPWD_OFF_CPH_BASE, 8'(v[k]));
      repeat (600) @(posedge mclk);
      count_high(0, 256);
      `CHK(c, 256 - v[k])
    end
    apb(1'b1, CAPWD_OFF_CPL_BASE, 8'h00);
    apb(1'b0, CAPWD_OFF_CPM_BASE, 8'h00);
    `CHK(rd[7:0], 8'h02)
    count_high(0, 256);
    `CHK(c, 0)
    apb(1'b1, CAPWD_OFF_CPH_BASE, 8'hFF);
    apb(1'b0, CAPWD_OFF_CPM_BASE, 8'h00);
    `CHK(rd[7:0], 8'h42)
  endtask

  task automatic t_pwm16;
    apb(1'b1, CAPWD_OFF_CTRL, 8'h00);
    apb(1'b1, CAPWD_OFF_CPM_BASE, 8'hCB);
    apb(1'b1, CAPWD_OFF_CPL_BASE, 8'h00);
    apb(1'b1, CAPWD_OFF_CNT_L, 8'h00);
    apb(1'b1, CAPWD_OFF_CNT_H, 8'hFE);
    apb(1'b1, CAPWD_OFF_CPH_BASE, 8'hFF);
    apb(1'b1, CAPWD_OFF_CTRL, 8'h40);
    count_high(0, 640);
    `CHK(c, 256)
    apb(1'b0, CAPWD_OFF_CTRL, 8'h00);
    `CHK(rd[0], 1'b1)
  endtask

  task automatic t_freq;
    int s[2] = '{32, 256};
    apb(1'b1, CAPWD_OFF_CPM_BASE + 8'h04, 8'h46);
    foreach (s[k]) begin
      apb(1'b1, CAPWD_OFF_CPL_BASE + 8'h04, 8'h10);
      apb(1'b1, CAPWD_OFF_CPH_BASE + 8'h04, 8'(s[k]));
      wait_toggle(1);
      wait_toggle(1);
      `CHK(c, s[k])
    end
  endtask

  initial begin
    do_reset();
    t_defaults();
    t_update();
    t_pwm8();
    t_pwm16();
    t_freq();
    results();
  end

endmodule // test_capwd_top

`default_nettype wire
